//--- src/ssl_driver.sv
`timescale 1ns/1ps
// Serial-in latched open-drain output controller with register view
module ssl_driver (
   input logic aclk,
   input logic aresetn,
   input logic ce,
   input logic serial_clock,
   input logic serial_data_in,
   input logic load_strobe,
   input logic clear_n,
   input logic output_disable,
   input logic overtemp_alarm,
   output logic cascade_data_out,
   input logic [7:0] drive_outputs_i,
   output logic [7:0] drive_outputs_o,
   output logic [7:0] drive_outputs_oe,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [11:0] s_axi_awaddr,
   input logic [2:0] s_axi_awprot,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   input logic [11:0] s_axi_araddr,
   input logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   // Whole register-side state
   typedef struct packed {
      ssl_pkg::ssl_pins_t s1;
      ssl_pkg::ssl_pins_t s2;
      ssl_pkg::ssl_pins_t s3;
      logic [7:0] rb1;
      logic [7:0] rb2;
      logic [7:0] rb3;
      ssl_pkg::ssl_pins_t pins;
      logic [7:0] pin_level;
      logic [7:0] held;
      logic [7:0] oe;
      logic cutoff;
      logic force_off;
      logic [15:0] loads;
      ssl_pkg::ssl_wstate_t wstate;
      logic aw_ok;
      logic w_ok;
      ssl_pkg::ssl_wr_t wr;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ssl_state_t;

   ssl_state_t cur;
   ssl_state_t next;

   logic [7:0] shift_word;
   logic [7:0] drive_on;
   logic [7:0] pin_vec;
   logic block_all;
   logic load_rise;
   logic clear_loads;
   ssl_pkg::ssl_pins_t pins_raw;
   ssl_pkg::ssl_reg_t wr_hit;
   ssl_pkg::ssl_reg_t rd_hit;

   // Word address to register; low two address bits are ignored
   function automatic ssl_pkg::ssl_reg_t reg_decode(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'b00};
      if (w == ssl_pkg::OFS_CTRL) begin
         return ssl_pkg::REG_CTRL;
      end else if (w == ssl_pkg::OFS_STATUS) begin
         return ssl_pkg::REG_STATUS;
      end else if (w == ssl_pkg::OFS_PINS) begin
         return ssl_pkg::REG_PINS;
      end else if (w == ssl_pkg::OFS_LOADS) begin
         return ssl_pkg::REG_LOADS;
      end else begin
         return ssl_pkg::REG_NONE;
      end
   endfunction : reg_decode

   // A bit moves only once the last two stages agree
   function automatic logic [7:0] settle(
      input logic [7:0] held_val,
      input logic [7:0] b,
      input logic [7:0] c
   );
      logic [7:0] agree;
      agree = ~(b ^ c);
      return (held_val & ~agree) | (c & agree);
   endfunction : settle

   // Serial-clock domain: shift register and cascade output
   ssl_link u_link (
      .serial_clock(serial_clock),
      .clear_n(clear_n),
      .serial_data_in(serial_data_in),
      .shift_word(shift_word),
      .cascade_data_out(cascade_data_out)
   );

   // Control pins gathered for capture
   assign pins_raw.load_strobe = load_strobe;
   assign pins_raw.clear_n = clear_n;
   assign pins_raw.output_disable = output_disable;
   assign pins_raw.overtemp_alarm = overtemp_alarm;

   // Any shared off condition opens every channel
   assign block_all = cur.pins.output_disable | cur.cutoff | cur.force_off; // R7 R9 R11

   // Each channel looks only at its own held bit
   genvar gi;
   generate
      for (gi = 0; gi < ssl_pkg::CH_COUNT; gi++) begin : g_chan
         assign drive_on[gi] = cur.held[gi] & ~block_all; // R4 R12
      end
   endgenerate

   // Next-state logic
   always_comb begin
      next = cur;
      load_rise = 1'b0;
      clear_loads = 1'b0;
      wr_hit = ssl_pkg::REG_NONE;
      rd_hit = ssl_pkg::REG_NONE;
      pin_vec = settle({4'h0, cur.pins}, {4'h0, cur.s2}, {4'h0, cur.s3});
      if (ce) begin
         // Three stages for asynchronous pins; stage one feeds only stage two
         next.s1 = pins_raw;
         next.s2 = cur.s1;
         next.s3 = cur.s2;
         next.rb1 = drive_outputs_i;
         next.rb2 = cur.rb1;
         next.rb3 = cur.rb2;
         next.pins = ssl_pkg::ssl_pins_t'(pin_vec[3:0]);
         next.pin_level = settle(cur.pin_level, cur.rb2, cur.rb3);

         // Strobe edge taken on the settled level, never on a raw stage
         load_rise = next.pins.load_strobe & ~cur.pins.load_strobe;

         // Shift word is quiet here: the host stops clocking before loading
         if (!next.pins.clear_n) begin
            next.held = ssl_pkg::HOLD_RESET; // R5
         end else if (load_rise) begin
            next.held = shift_word; // R2
         end
         // Otherwise the held byte stays as it is R3

         // Disable suspends the thermal cutoff; release is automatic
         // Taken from the new settled pins so cutoff and disable move on one edge,
         // otherwise a hot channel blinks on for a cycle when disable drops
         next.cutoff = next.pins.overtemp_alarm & ~next.pins.output_disable; // R8 R11

         // Output enables come from a flop
         next.oe = drive_on; // R4 R7 R12

         // Write address and data taken in either order
         if (s_axi_awvalid && s_axi_awready) begin
            next.aw_ok = 1'b1;
            next.wr.addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            next.w_ok = 1'b1;
            next.wr.data = s_axi_wdata;
            next.wr.strb = s_axi_wstrb;
         end

         // Commit once both halves are in
         case (cur.wstate)
            ssl_pkg::W_COLLECT: begin
               if (cur.aw_ok && cur.w_ok) begin
                  wr_hit = reg_decode(cur.wr.addr);
                  next.aw_ok = 1'b0;
                  next.w_ok = 1'b0;
                  next.wstate = ssl_pkg::W_RESP;
                  if (wr_hit == ssl_pkg::REG_NONE) begin
                     next.bresp = ssl_pkg::RESP_DECERR;
                  end else begin
                     next.bresp = ssl_pkg::RESP_OKAY;
                  end
               end
            end
            ssl_pkg::W_RESP: begin
               next.wstate = cur.wstate;
            end
            default: begin
               next.wstate = ssl_pkg::W_COLLECT;
            end
         endcase

         // Only the low byte of the control word holds fields
         if (wr_hit == ssl_pkg::REG_CTRL && cur.wr.strb[0]) begin
            next.force_off = cur.wr.data[ssl_pkg::CTRL_FORCE_OFF_BIT];
            clear_loads = cur.wr.data[ssl_pkg::CTRL_CLR_LOADS_BIT];
         end

         // A load in the same cycle as a clear still counts
         if (clear_loads) begin
            next.loads = ssl_pkg::LOADS_RESET;
         end
         if (load_rise) begin
            next.loads = next.loads + 16'h0001;
         end

         // Read answer built from the current state
         if (!cur.rvalid && s_axi_arvalid) begin
            rd_hit = reg_decode(s_axi_araddr);
            next.rvalid = 1'b1;
            next.rdata = ssl_pkg::WORD_ZERO;
            next.rresp = ssl_pkg::RESP_OKAY;
            if (rd_hit == ssl_pkg::REG_CTRL) begin
               next.rdata[ssl_pkg::CTRL_FORCE_OFF_BIT] = cur.force_off;
            end else if (rd_hit == ssl_pkg::REG_STATUS) begin
               next.rdata[ssl_pkg::STAT_HELD_LSB +: 8] = cur.held;
               next.rdata[ssl_pkg::STAT_CUTOFF_BIT] = cur.cutoff;
               next.rdata[ssl_pkg::STAT_DISABLE_BIT] = cur.pins.output_disable;
               next.rdata[ssl_pkg::STAT_CLEAR_N_BIT] = cur.pins.clear_n;
               next.rdata[ssl_pkg::STAT_ALARM_BIT] = cur.pins.overtemp_alarm;
               next.rdata[ssl_pkg::STAT_STROBE_BIT] = cur.pins.load_strobe;
            end else if (rd_hit == ssl_pkg::REG_PINS) begin
               next.rdata[ssl_pkg::PINS_OE_LSB +: 8] = cur.oe;
               next.rdata[ssl_pkg::PINS_LEVEL_LSB +: 8] = cur.pin_level;
            end else if (rd_hit == ssl_pkg::REG_LOADS) begin
               next.rdata[15:0] = cur.loads;
            end else begin
               next.rresp = ssl_pkg::RESP_DECERR;
            end
         end
      end

      // Retiring an answer ignores ce so a taken answer is never repeated
      if (cur.wstate == ssl_pkg::W_RESP && s_axi_bready) begin
         next.wstate = ssl_pkg::W_COLLECT;
      end
      if (cur.rvalid && s_axi_rready) begin
         next.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur <= '0;
         cur.held <= ssl_pkg::HOLD_RESET;
         cur.loads <= ssl_pkg::LOADS_RESET;
         cur.wstate <= ssl_pkg::W_COLLECT;
      end else begin
         cur <= next;
      end
   end

   // Open drain: pin level is never driven high
   assign drive_outputs_o = ssl_pkg::HOLD_RESET;
   assign drive_outputs_oe = cur.oe; // R4 R12

   // Bus handshakes; readies drop while ce is low
   assign s_axi_awready = ce & ~cur.aw_ok & (cur.wstate == ssl_pkg::W_COLLECT);
   assign s_axi_wready = ce & ~cur.w_ok & (cur.wstate == ssl_pkg::W_COLLECT);
   assign s_axi_bvalid = (cur.wstate == ssl_pkg::W_RESP);
   assign s_axi_bresp = cur.bresp;
   assign s_axi_arready = ce & ~cur.rvalid;
   assign s_axi_rvalid = cur.rvalid;
   assign s_axi_rdata = cur.rdata;
   assign s_axi_rresp = cur.rresp;
endmodule : ssl_driver

//--- include/ssl_pkg.sv
// Contract
// (R1) Each serial clock rise shifts the serial input level into the 8-bit shift register.
// (R2) A load strobe rise copies the whole shift register into the holding register.
// (R3) The holding register keeps its value until the next load strobe rise.
// (R4) Each held bit drives the output of the same index; one conducts, zero is open.
// (R5) While clear is low the shift and holding registers are zero and all outputs open.
// (R6) The host holds clear low or undriven during power-up.
// (R7) While output disable is high all eight outputs are open.
// (R8) While output disable is high the over-temperature cutoff is suspended.
// (R9) A PWM wave on output disable lets enabled outputs conduct only in its low phases.
// (R10) The cascade output changes on the serial clock fall.
// (R11) An over-temperature alarm opens all outputs; they resume when it clears.
// (R12) Eight outputs, each gated only by its own bit and the shared off conditions.
// (R13) In a chain the host gives eight extra clocks per downstream device before loading.
// (R14) Data goes MSB first; the first bit ends in bit 7, the last in bit 0.
// (R15) The cascade output carries bit 7 of the shift register, the oldest bit.
package ssl_pkg;
   // Geometry
   localparam int unsigned CH_COUNT = 8;
   localparam int unsigned ADDR_W = 12;

   // Register offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_PINS = 12'h008;
   localparam logic [11:0] OFS_LOADS = 12'h00c;

   // Control fields
   localparam int unsigned CTRL_FORCE_OFF_BIT = 0;
   localparam int unsigned CTRL_CLR_LOADS_BIT = 1;

   // Status fields
   localparam int unsigned STAT_HELD_LSB = 0;
   localparam int unsigned STAT_CUTOFF_BIT = 8;
   localparam int unsigned STAT_DISABLE_BIT = 9;
   localparam int unsigned STAT_CLEAR_N_BIT = 10;
   localparam int unsigned STAT_ALARM_BIT = 11;
   localparam int unsigned STAT_STROBE_BIT = 12;

   // Pin view fields
   localparam int unsigned PINS_OE_LSB = 0;
   localparam int unsigned PINS_LEVEL_LSB = 8;

   // Reset values
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [15:0] LOADS_RESET = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Register selector
   typedef enum logic [2:0] {
      REG_NONE,
      REG_CTRL,
      REG_STATUS,
      REG_PINS,
      REG_LOADS
   } ssl_reg_t;

   // Write channel progress
   typedef enum logic [0:0] {
      W_COLLECT,
      W_RESP
   } ssl_wstate_t;

   // Asynchronous control pins, sampled together
   typedef struct packed {
      logic load_strobe;
      logic clear_n;
      logic output_disable;
      logic overtemp_alarm;
   } ssl_pins_t;

   // One captured register write
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } ssl_wr_t;
endpackage : ssl_pkg

//--- src/ssl_link.sv
`timescale 1ns/1ps
// Shift register and cascade stage, clocked by the serial clock itself
module ssl_link (
   input logic serial_clock,
   input logic clear_n,
   input logic serial_data_in,
   output logic [7:0] shift_word,
   output logic cascade_data_out
);
   typedef struct packed {
      logic [7:0] shift;
   } ssl_link_state_t;

   ssl_link_state_t cur;
   ssl_link_state_t next;

   // Newest bit enters at bit 0, so the first bit ends at bit 7
   always_comb begin
      next = cur;
      next.shift = {cur.shift[6:0], serial_data_in}; // R1 R14
   end

   // Clear acts without a clock edge, the serial clock may be stopped
   always_ff @(posedge serial_clock or negedge clear_n) begin
      if (!clear_n) begin
         cur.shift <= ssl_pkg::SHIFT_RESET; // R5
      end else begin
         cur <= next; // R1
      end
   end

   // Fall-edge update gives the next device half a period of setup
   always_ff @(negedge serial_clock or negedge clear_n) begin
      if (!clear_n) begin
         cascade_data_out <= 1'b0;
      end else begin
         cascade_data_out <= cur.shift[7]; // R10 R15
      end
   end

   assign shift_word = cur.shift;
endmodule : ssl_link

//--- tb/ssl_host.sv
`timescale 1ns/1ps
// Host on the serial lines: the clock runs only inside a frame
module ssl_host (
   output logic serial_clock,
   output logic serial_data_in,
   output logic load_strobe
);
   initial begin
      serial_clock = 1'b0;
      serial_data_in = 1'b0;
      load_strobe = 1'b0;
   end

   // One byte, oldest bit first, 12 ns clock period
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #1 serial_data_in = b[i];
         #5 serial_clock = 1'b1;
         #6 serial_clock = 1'b0;
      end
      // Released line shows the inverse, never a stale level
      #1 serial_data_in = ~serial_data_in;
   endtask : send

   // Clock quiet before the strobe; pulse outlasts the pin synchroniser
   task automatic latch();
      #200 load_strobe = 1'b1;
      #48 load_strobe = 1'b0;
      #48;
   endtask : latch
endmodule : ssl_host

//--- tb/ssl_checker.sv
`timescale 1ns/1ps
// Port checks on output gating, bus answers and the cascade stage
module ssl_checker (
   input logic aclk,
   input logic aresetn,
   input logic serial_clock,
   input logic serial_data_in,
   input logic clear_n,
   input logic output_disable,
   input logic overtemp_alarm,
   input logic cascade_data_out,
   input logic [7:0] drive_outputs_o,
   input logic [7:0] drive_outputs_oe,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata
);
   // Rises since clear; the cascade only holds real data after eight
   logic [3:0] rises;
   always_ff @(posedge serial_clock or negedge clear_n) begin
      if (!clear_n) rises <= 4'h0;
      else if (rises != 4'h8) rises <= rises + 4'h1;
   end

   // Write taken on both channels, then answer after the commit edge
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence answer_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence

   off_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      output_disable [*8] |-> drive_outputs_oe == 8'h00) else $error("driven while disabled");
   off_alarm_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (overtemp_alarm && !output_disable) [*8] |-> drive_outputs_oe == 8'h00)
      else $error("driven while hot");
   off_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!clear_n) [*8] |-> drive_outputs_oe == 8'h00) else $error("driven while cleared");
   open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
      drive_outputs_o == 8'h00) else $error("pin driven high");
   write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_w_taken |-> ##1 answer_late) else $error("write answer late");
   read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   cascade_order_a: assert property (@(posedge serial_clock) disable iff (!clear_n)
      rises == 4'h8 |-> cascade_data_out == $past(serial_data_in, 8))
      else $error("cascade bit wrong");
endmodule : ssl_checker

bind ssl_driver ssl_checker chk_i (.aclk(aclk), .aresetn(aresetn),
   .serial_clock(serial_clock), .serial_data_in(serial_data_in), .clear_n(clear_n),
   .output_disable(output_disable), .overtemp_alarm(overtemp_alarm),
   .cascade_data_out(cascade_data_out), .drive_outputs_o(drive_outputs_o),
   .drive_outputs_oe(drive_outputs_oe), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

//--- tb/serial_shift_latch_driver_tb.sv
`timescale 1ns/1ps
// Host model on the serial side, bus master on the register side
module serial_shift_latch_driver_tb;
   localparam logic [11:0] CT = ssl_pkg::OFS_CTRL;
   localparam logic [11:0] ST = ssl_pkg::OFS_STATUS;
   localparam logic [11:0] PN = ssl_pkg::OFS_PINS;
   localparam logic [11:0] LD = ssl_pkg::OFS_LOADS;
   localparam logic [1:0] OK = ssl_pkg::RESP_OKAY;
   localparam logic [1:0] DE = ssl_pkg::RESP_DECERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clear_n = 1'b0;
   logic output_disable = 1'b0;
   logic overtemp_alarm = 1'b0;
   logic ce = 1'b1;
   logic [3:0] strb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic sclk, sdi, load, casc, awready, wready, bvalid, arready, rvalid;
   logic [7:0] oe, o_lvl, pin_lvl;
   logic [31:0] rdata;
   logic [1:0] bresp, rresp;
   int n_fail = 0;
   int num_checks = 0;

   always #4 aclk = ~aclk;
   // Open-drain channels with pull-ups
   assign pin_lvl = (o_lvl & oe) | ~oe;

   ssl_host host (.serial_clock(sclk), .serial_data_in(sdi), .load_strobe(load));
   ssl_driver uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .serial_clock(sclk),
      .serial_data_in(sdi), .load_strobe(load), .clear_n(clear_n),
      .output_disable(output_disable), .overtemp_alarm(overtemp_alarm),
      .cascade_data_out(casc), .drive_outputs_i(pin_lvl), .drive_outputs_o(o_lvl),
      .drive_outputs_oe(oe), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(addr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(addr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One access; ready is raised only after the answer shows, to test holding
   task automatic acc(input bit w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [1:0] er);
      logic done, ta, tw, tr;
      logic [31:0] rd;
      logic [1:0] rr;
      done = 1'b0;
      @(posedge aclk);
      addr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      while (!done) begin
         @(negedge aclk);
         done = w ? (bready && bvalid) : (rready && rvalid);
         rr = w ? bresp : rresp;
         rd = rdata;
         ta = awready;
         tw = wready;
         tr = arready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         bready <= w && bvalid && !done;
         rready <= !w && rvalid && !done;
      end
      chk(32'(rr), 32'(er));
      if (!w) chk(rd & m, d);
   endtask : acc

   // Strobe the shifted byte in and compare the driven channels
   task automatic settle(input logic [7:0] exp);
      host.latch();
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'(exp));
   endtask : settle

   task automatic conclude();
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      conclude();
   end

   initial begin
      // Clear held low through power-up, released with the bus reset
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      clear_n <= 1'b1;
      host.send(8'ha5);
      chk(32'(casc), 32'h0000_0001);
      settle(8'ha5);
      acc(0, ST, 32'h0000_00a5, 32'h0000_00ff, OK);
      acc(0, PN, 32'h0000_5aa5, 32'h0000_ffff, OK);
      // Shifting alone must not disturb the held byte
      host.send(8'h3c);
      chk(32'(casc), 32'h0000_0000);
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_00a5);
      settle(8'h3c);
      for (int i = 0; i < 8; i++) begin
         host.send(8'h01 << i);
         settle(8'h01 << i);
      end
      // Two bytes back to back: the first leaves by the cascade stage
      host.send(8'h81);
      host.send(8'hff);
      settle(8'hff);
      output_disable <= 1'b1;
      overtemp_alarm <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_0000);
      acc(0, ST, 32'h0000_0a00, 32'h0000_0b00, OK);
      output_disable <= 1'b0;
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_0000);
      acc(0, ST, 32'h0000_0900, 32'h0000_0b00, OK);
      overtemp_alarm <= 1'b0;
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_00ff);
      // Dimming wave on the disable input
      for (int i = 0; i < 3; i++) begin
         output_disable <= 1'b1;
         repeat (12) @(posedge aclk);
         chk(32'(oe), 32'h0000_0000);
         output_disable <= 1'b0;
         repeat (12) @(posedge aclk);
         chk(32'(oe), 32'h0000_00ff);
      end
      // Force-off bit, read-only counter, unmapped place
      acc(1, CT, 32'h0000_0003, 32'h0000_0000, OK);
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_0000);
      acc(0, CT, 32'h0000_0001, 32'h0000_0003, OK);
      acc(1, CT, 32'h0000_0000, 32'h0000_0000, OK);
      // Control write without its low byte lane leaves the field alone
      strb <= 4'he;
      acc(1, CT, 32'h0000_0001, 32'h0000_0000, OK);
      acc(0, CT, 32'h0000_0000, 32'h0000_0001, OK);
      strb <= 4'hf;
      acc(1, LD, 32'h0000_ffff, 32'h0000_0000, OK);
      acc(0, LD, 32'h0000_0000, 32'h0000_ffff, OK);
      acc(1, 12'h010, 32'h0000_0001, 32'h0000_0000, DE);
      acc(0, 12'h010, 32'h0000_0000, 32'h0000_0000, DE);
      host.send(8'h66);
      // Clock enable low freezes the pin stages, so a strobe in that gap is lost
      @(posedge aclk);
      ce <= 1'b0;
      host.latch();
      @(posedge aclk);
      ce <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_00ff);
      settle(8'h66);
      acc(0, LD, 32'h0000_0001, 32'h0000_ffff, OK);
      // Clear in mid-run: strobe leaves the held byte zero and status reads zero; the load counter still counts it
      clear_n <= 1'b0;
      repeat (12) @(posedge aclk);
      chk(32'(oe), 32'h0000_0000);
      host.latch();
      acc(0, ST, 32'h0000_0000, 32'h0000_04ff, OK);
      clear_n <= 1'b1;
      host.send(8'h5a);
      settle(8'h5a);
      conclude();
   end
endmodule : serial_shift_latch_driver_tb
